// [src/rsc_port.sv]
// serial command interpreter: two bytes in, five reply bytes out
// Notes on behaviour
// R1: commands are code byte then parameter byte, 9600 baud 8N1.
// R2: each received command pair produces exactly five reply bytes.
// R3: host waits for all five reply bytes before next command.
// R4: reply bytes four and five form a 16-bit value, high byte first.
// R5: code 24 returns bumper, feel, line and compass heading.
// R6: code 201 enters arm mode; parameter 0, 1, 2 select variant.
// R7: arm mode keeps two-in five-out framing and accepts arm codes.
// R8: code 203 returns digital sense inputs in reply byte three.
// R9: code 6 moves forward by parameter units.
// R10: code 12 turns right by parameter degrees.
// R11: code 138 small DC motors, 139/131 six rangers, 3 locate.
// R12: motion replies carry bumper in byte one, feel in byte two.
// R13: host link uses its own dedicated receive and transmit pins.
// R14: reply is sent only after the commanded action completes.
`timescale 1ns/100ps
`default_nettype none
module rsc_port
    import rsc_pkg::*;
#(
    // bit time in clock cycles; the default gives 9600 baud at 25 MHz
    parameter int unsigned BIT_CYCLES = BIT_CYC
)
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // dedicated host serial pins
    input wire logic host_rx_in,
    output logic host_tx_out,
    // action handshake to motion and setup logic
    output logic action_start_out,
    output rsc_action_t action_out,
    input wire logic action_done_in,
    // sensor state
    input wire rsc_sensors_t sensors_in,
    // mode status
    output logic arm_mode_out,
    output logic [1:0] arm_variant_out,
    output logic dc_motor_cfg_out,
    output logic six_ranger_cfg_out
);
    // counter reloads; the half bit puts every sample in mid-bit
    localparam logic [CNT_W-1:0] BIT_END = CNT_W'(BIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] HALF_END = CNT_W'(BIT_CYCLES / 2 - 1);

    // receiver state
    logic rx_s1_r, rx_s2_r;
    logic rx_busy_r, rx_busy_nxt;
    logic [CNT_W-1:0] rx_cnt_r, rx_cnt_nxt;
    logic [3:0] rx_bit_r, rx_bit_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    logic rx_vld_r, rx_vld_nxt;
    // transmitter state
    logic tx_busy_r, tx_busy_nxt;
    logic [CNT_W-1:0] tx_cnt_r, tx_cnt_nxt;
    logic [3:0] tx_bit_r, tx_bit_nxt;
    logic [9:0] tx_sh_r, tx_sh_nxt;
    logic tx_line_r, tx_line_nxt;
    logic tx_go;
    logic [7:0] tx_byte;
    // command state
    rsc_cmd_state_t st_r, st_nxt;
    rsc_cmd_t cmd_r, cmd_nxt;
    logic [7:0] reply_r [0:4];
    logic [7:0] reply_nxt [0:4];
    logic [2:0] idx_r, idx_nxt;
    logic start_r, start_nxt;
    logic arm_r, arm_nxt;
    logic [1:0] var_r, var_nxt;
    logic dc_r, dc_nxt;
    logic six_r, six_nxt;

    // decide whether a code needs the external action handshake
    function automatic logic needs_action(input logic [7:0] code);
        needs_action = (code == CMD_FORWARD) || (code == CMD_RIGHT) || (code == CMD_LOCATE);
    endfunction

    // input synchroniser; second stage is the only reader of the first
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            rx_s1_r <= host_rx_in;
            rx_s2_r <= rx_s1_r;
        end
    end

    // receiver: start bit checked at mid-bit, then eight data bits lsb first
    always_comb begin
        rx_busy_nxt = rx_busy_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_bit_nxt = rx_bit_r;
        rx_sh_nxt = rx_sh_r;
        rx_vld_nxt = 1'b0;
        if (!rx_busy_r) begin
            if (!rx_s2_r) begin
                rx_busy_nxt = 1'b1;
                rx_cnt_nxt = HALF_END;
                rx_bit_nxt = 4'h0;
            end
        end else if (rx_cnt_r != '0) begin
            rx_cnt_nxt = rx_cnt_r - 1'b1;
        end else begin
            rx_cnt_nxt = BIT_END;
            rx_bit_nxt = rx_bit_r + 1'b1;
            if (rx_bit_r == 4'h0) begin
                // glitch on the start bit: abandon
                if (rx_s2_r) begin
                    rx_busy_nxt = 1'b0;
                end
            end else if (rx_bit_r < FRAME_BITS) begin
                rx_sh_nxt = {rx_s2_r, rx_sh_r[7:1]};
            end else begin
                // stop bit; a framing error drops the byte
                rx_busy_nxt = 1'b0;
                rx_vld_nxt = rx_s2_r; // R1
            end
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_busy_r <= 1'b0;
            rx_cnt_r <= '0;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
            rx_vld_r <= 1'b0;
        end else begin
            rx_busy_r <= rx_busy_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_bit_r <= rx_bit_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_vld_r <= rx_vld_nxt;
        end
    end

    // transmitter: start, eight data lsb first, stop
    always_comb begin
        tx_busy_nxt = tx_busy_r;
        tx_cnt_nxt = tx_cnt_r;
        tx_bit_nxt = tx_bit_r;
        tx_sh_nxt = tx_sh_r;
        tx_line_nxt = tx_line_r;
        if (!tx_busy_r) begin
            tx_line_nxt = 1'b1;
            if (tx_go) begin
                tx_busy_nxt = 1'b1;
                tx_sh_nxt = {1'b1, tx_byte, 1'b0};
                tx_cnt_nxt = BIT_END;
                tx_bit_nxt = 4'h0;
                tx_line_nxt = 1'b0;
            end
        end else if (tx_cnt_r != '0) begin
            tx_cnt_nxt = tx_cnt_r - 1'b1;
        end else if (tx_bit_r == FRAME_BITS) begin
            // stop bit finished
            tx_busy_nxt = 1'b0;
            tx_line_nxt = 1'b1;
        end else begin
            tx_cnt_nxt = BIT_END;
            tx_bit_nxt = tx_bit_r + 1'b1;
            tx_sh_nxt = {1'b1, tx_sh_r[9:1]};
            tx_line_nxt = tx_sh_r[1];
        end
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_busy_r <= 1'b0;
            tx_cnt_r <= '0;
            tx_bit_r <= 4'h0;
            tx_sh_r <= 10'h3ff;
            tx_line_r <= 1'b1;
        end else begin
            tx_busy_r <= tx_busy_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_bit_r <= tx_bit_nxt;
            tx_sh_r <= tx_sh_nxt;
            tx_line_r <= tx_line_nxt;
        end
    end

    // reply bytes go out one per idle transmitter slot
    assign tx_go = (st_r == CS_REPLY) && !tx_busy_r; // R2
    assign tx_byte = reply_r[idx_r];

    // command sequencer
    always_comb begin
        st_nxt = st_r;
        cmd_nxt = cmd_r;
        idx_nxt = idx_r;
        start_nxt = 1'b0;
        arm_nxt = arm_r;
        var_nxt = var_r;
        dc_nxt = dc_r;
        six_nxt = six_r;
        for (int i = 0; i < 5; i++) begin
            reply_nxt[i] = reply_r[i];
        end
        case (st_r)
            CS_IDLE: begin
                // bytes arriving after the pair until the fifth reply byte starts are ignored; host must wait
                if (rx_vld_r) begin // R3
                    cmd_nxt.code = rx_sh_r;
                    st_nxt = CS_PARAM;
                end
            end
            CS_PARAM: begin
                if (rx_vld_r) begin // R1
                    cmd_nxt.param = rx_sh_r;
                    st_nxt = CS_EXEC;
                end
            end
            CS_EXEC: begin
                // same framing in either mode; arm codes handed to the action port
                if (needs_action(cmd_r.code) || arm_r) begin // R7
                    start_nxt = 1'b1; // R9 R10
                    st_nxt = CS_WAIT;
                end else begin
                    st_nxt = CS_WAIT;
                end
                case (cmd_r.code)
                    CMD_DC_SETUP: dc_nxt = 1'b1; // R11
                    CMD_SENSOR_SETUP: begin
                        if (cmd_r.param == PARAM_SIX_RANGERS) begin
                            six_nxt = 1'b1; // R11
                        end
                    end
                    CMD_ARM_CONVERT: begin
                        // unknown variants are ignored to keep the mode stable
                        if (cmd_r.param[7:2] == 6'h00 && cmd_r.param[1:0] != 2'h3) begin
                            arm_nxt = 1'b1; // R6
                            var_nxt = cmd_r.param[1:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            CS_WAIT: begin
                // snapshot sensors only once the action has finished
                if (!action_start_out || action_done_in) begin // R14
                    reply_nxt[0] = sensors_in.bumper; // R5 R12
                    reply_nxt[1] = sensors_in.feel; // R12
                    reply_nxt[2] = (cmd_r.code == CMD_SENSE_READ) ? sensors_in.sense : sensors_in.line; // R8
                    reply_nxt[3] = sensors_in.heading[15:8]; // R4
                    reply_nxt[4] = sensors_in.heading[7:0]; // R4 R5
                    idx_nxt = 3'h0;
                    st_nxt = CS_REPLY;
                end
                start_nxt = action_start_out && !action_done_in;
            end
            CS_REPLY: begin
                if (tx_go) begin
                    if (idx_r == REPLY_LEN - 3'h1) begin
                        st_nxt = CS_IDLE;
                    end
                    idx_nxt = idx_r + 3'h1;
                end
            end
            default: st_nxt = CS_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r <= CS_IDLE;
            cmd_r <= '0;
            idx_r <= 3'h0;
            start_r <= 1'b0;
            arm_r <= 1'b0;
            var_r <= ARM_MODE_RST;
            dc_r <= 1'b0;
            six_r <= 1'b0;
            for (int i = 0; i < 5; i++) begin
                reply_r[i] <= 8'h00;
            end
        end else begin
            st_r <= st_nxt;
            cmd_r <= cmd_nxt;
            idx_r <= idx_nxt;
            start_r <= start_nxt;
            arm_r <= arm_nxt;
            var_r <= var_nxt;
            dc_r <= dc_nxt;
            six_r <= six_nxt;
            for (int i = 0; i < 5; i++) begin
                reply_r[i] <= reply_nxt[i];
            end
        end
    end

    // outputs straight from flip-flops
    assign host_tx_out = tx_line_r; // R13
    assign action_start_out = start_r;
    assign action_out = cmd_r;
    assign arm_mode_out = arm_r;
    assign arm_variant_out = var_r;
    assign dc_motor_cfg_out = dc_r;
    assign six_ranger_cfg_out = six_r;
endmodule
`default_nettype wire

// [src/rsc_pkg.sv]
// shared constants and types for the robot serial command port
package rsc_pkg;
    // serial timing: 9600 baud at 25 MHz
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned BAUD = 9600;
    localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
    localparam int unsigned HALF_CYC = BIT_CYC / 2;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYC - 1);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
    // framing
    localparam logic [2:0] REPLY_LEN = 3'h5;
    localparam logic [3:0] FRAME_BITS = 4'h9;
    // command codes
    localparam logic [7:0] CMD_LOCATE = 8'h03;
    localparam logic [7:0] CMD_FORWARD = 8'h06;
    localparam logic [7:0] CMD_RIGHT = 8'h0c;
    localparam logic [7:0] CMD_COMPASS = 8'h18;
    localparam logic [7:0] CMD_DC_SETUP = 8'h8a;
    localparam logic [7:0] CMD_SENSOR_SETUP = 8'h8b;
    localparam logic [7:0] PARAM_SIX_RANGERS = 8'h83;
    localparam logic [7:0] CMD_ARM_CONVERT = 8'hc9;
    localparam logic [7:0] CMD_SENSE_READ = 8'hcb;
    // arm variants
    localparam logic [1:0] ARM_NORMAL = 2'h0;
    localparam logic [1:0] ARM_OUTPUTS = 2'h1;
    localparam logic [1:0] ARM_NAV = 2'h2;
    // reset values
    localparam logic [1:0] ARM_MODE_RST = 2'h0;

    // command pair as received
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] param;
    } rsc_cmd_t;

    // action request to the motion/setup logic
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] param;
    } rsc_action_t;

    // sensor snapshot used to build replies
    typedef struct packed {
        logic [7:0] bumper;
        logic [7:0] feel;
        logic [7:0] line;
        logic [7:0] sense;
        logic [15:0] heading;
    } rsc_sensors_t;

    typedef enum logic [2:0] {
        CS_IDLE, CS_PARAM, CS_EXEC, CS_WAIT, CS_REPLY
    } rsc_cmd_state_t;
endpackage

// [bench/rsc_port_properties.sv]
// concurrent checks on the serial command port outputs
`timescale 1ns/100ps
`default_nettype none
module rsc_port_properties
    import rsc_pkg::*;
#(
    // bit time of the bound port
    parameter int unsigned BIT_CYCLES = BIT_CYC
)
(
    // clock and reset
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // watched ports
    input wire logic host_tx_out,
    input wire logic action_start_out,
    input wire rsc_action_t action_out,
    input wire logic action_done_in,
    input wire logic arm_mode_out,
    input wire logic [1:0] arm_variant_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    localparam logic [CNT_W-1:0] BIT_END = CNT_W'(BIT_CYCLES - 1);

    // cycles the tx level has stood, saturating at one bit time
    logic tx_q_r, tx_q_nxt;
    logic [CNT_W-1:0] run_r, run_nxt;
    always_comb begin
        tx_q_nxt = host_tx_out;
        run_nxt = (host_tx_out != tx_q_r) ? 12'h0 : ((run_r == BIT_END) ? run_r : run_r + 12'h1);
    end
    // saturated after reset so the first start edge is legal
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_q_r <= 1'b1;
            run_r <= BIT_END;
        end else begin
            tx_q_r <= tx_q_nxt;
            run_r <= run_nxt;
        end
    end

    a_reset_idle: assert property ($rose(reset_n_in) |-> host_tx_out && !action_start_out && !arm_mode_out)
        else $error("outputs not idle after reset");
    a_tx_bit_width: assert property (host_tx_out != tx_q_r |-> run_r == BIT_END)
        else $error("tx level shorter than one bit");
    a_start_holds: assert property (action_start_out && !action_done_in |=> action_start_out)
        else $error("action request dropped early");
    a_start_drops: assert property (action_start_out && action_done_in |=> !action_start_out)
        else $error("action request not released");
    a_action_stable: assert property (action_start_out ##1 action_start_out |-> $stable(action_out))
        else $error("action request changed while pending");
    a_quiet_in_action: assert property (action_start_out |-> host_tx_out)
        else $error("reply sent before action finished");
    a_arm_sticky: assert property (arm_mode_out |=> arm_mode_out)
        else $error("arm mode left without reset");
    a_variant_idle: assert property (!arm_mode_out |-> arm_variant_out == ARM_NORMAL)
        else $error("variant set outside arm mode");
    a_variant_legal: assert property (arm_variant_out != 2'h3)
        else $error("illegal arm variant");

    c_action_done: cover property (action_start_out && action_done_in);
    c_arm_entered: cover property ($rose(arm_mode_out));
    c_reply_start: cover property ($fell(host_tx_out));
endmodule
`default_nettype wire

// [bench/rsc_host_model.sv]
// host side: sends command pairs and collects five byte replies
`timescale 1ns/100ps
`default_nettype none
module rsc_host_model
    import rsc_pkg::*;
#(
    // bit time in clock cycles, matched to the port under test
    parameter int unsigned BIT_CYCLES = BIT_CYC
)
(
    // clock
    input wire logic mclk_in,
    // serial lines
    input wire logic host_tx_in,
    output logic host_rx_out
);
    initial host_rx_out = 1'b1;

    // one 8n1 frame, lsb first, driven off the sampling edge
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge mclk_in);
            host_rx_out = f[i];
            repeat (BIT_CYCLES - 1) @(negedge mclk_in);
        end
    endtask

    // code byte first, then its parameter
    task automatic send_pair(input rsc_cmd_t c);
        send_byte(c.code);
        send_byte(c.param);
    endtask

    // whole reply taken before the caller may send again
    task automatic recv_reply(output logic [39:0] r, output bit ok);
        int n;
        ok = 1'b1;
        r = 40'h0;
        for (int k = 0; k < 5 && ok; k++) begin
            n = 0;
            // bound covers the command bytes plus a short action
            while (host_tx_in !== 1'b0 && n < 32 * BIT_CYCLES) begin
                @(negedge mclk_in);
                n++;
            end
            ok = (n < 32 * BIT_CYCLES);
            repeat (BIT_CYCLES / 2) @(negedge mclk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(negedge mclk_in);
                r[8*(4-k)+i] = host_tx_in;
            end
            repeat (BIT_CYCLES) @(negedge mclk_in);
            if (host_tx_in !== 1'b1) ok = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// [bench/rsc_port_tb_top.sv]
// top bench for the serial command port
`timescale 1ns/100ps
`default_nettype none
module rsc_port_tb_top
    import rsc_pkg::*;
;
    // short bit time keeps the run brief; framing and counters are unchanged
    localparam int unsigned TB_BIT_CYC = 40;
    logic mclk_in, reset_n_in, host_rx_in, host_tx_out, action_start_out, action_done_in;
    logic arm_mode_out, dc_motor_cfg_out, six_ranger_cfg_out;
    logic [1:0] arm_variant_out;
    logic [39:0] reply, exp_r;
    rsc_action_t action_out, seen_act;
    rsc_sensors_t sensors_in;
    rsc_cmd_t cmds [10];
    bit acts [10];
    bit ok;
    int bad_count, total_checks, done_count, done_base;

    rsc_port #(.BIT_CYCLES(TB_BIT_CYC)) i_rsc_port (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .host_rx_in(host_rx_in),
        .host_tx_out(host_tx_out),
        .action_start_out(action_start_out),
        .action_out(action_out),
        .action_done_in(action_done_in),
        .sensors_in(sensors_in),
        .arm_mode_out(arm_mode_out),
        .arm_variant_out(arm_variant_out),
        .dc_motor_cfg_out(dc_motor_cfg_out),
        .six_ranger_cfg_out(six_ranger_cfg_out)
    );
    rsc_host_model #(.BIT_CYCLES(TB_BIT_CYC)) i_rsc_host_model (.mclk_in(mclk_in), .host_tx_in(host_tx_out),
        .host_rx_out(host_rx_in));

    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end

    // far-side action logic: random short finish time, request recorded, finishes counted
    always @(negedge mclk_in) begin
        if (action_start_out === 1'b1) begin
            seen_act <= action_out;
        end
        if (action_done_in === 1'b1) begin
            done_count <= done_count + 1;
        end
        action_done_in <= (action_start_out === 1'b1) && !action_done_in && ($urandom_range(3) == 0);
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // reply layout: bumper, feel, line or sense, heading high then low
    function automatic logic [39:0] exp_reply(input logic [7:0] code, input rsc_sensors_t s);
        return {s.bumper, s.feel, (code == CMD_SENSE_READ) ? s.sense : s.line, s.heading};
    endfunction

    initial begin
        reset_n_in = 1'b0;
        sensors_in = '0;
        bad_count = 0;
        total_checks = 0;
        void'($urandom(54));
        // last entry runs in arm mode, where every code waits for the action
        cmds = '{'{CMD_COMPASS, 8'h00}, '{CMD_SENSE_READ, 8'h00}, '{CMD_FORWARD, 8'h00},
                 '{CMD_RIGHT, 8'hff}, '{CMD_LOCATE, 8'h00}, '{CMD_DC_SETUP, 8'h00},
                 '{CMD_SENSOR_SETUP, PARAM_SIX_RANGERS}, '{CMD_ARM_CONVERT, 8'h03},
                 '{CMD_ARM_CONVERT, {6'h0, ARM_NAV}}, '{CMD_COMPASS, 8'h00}};
        acts = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        cmds[2].param = 8'($urandom());
        repeat (12) @(negedge mclk_in);
        reset_n_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        chk("idle outputs", 16'h0040, {9'h0, host_tx_out, action_start_out, arm_mode_out, arm_variant_out,
            dc_motor_cfg_out, six_ranger_cfg_out});
        for (int k = 0; k < 10; k++) begin
            sensors_in = {$urandom(), 16'($urandom())};
            done_base = done_count;
            fork
                i_rsc_host_model.send_pair(cmds[k]);
                i_rsc_host_model.recv_reply(reply, ok);
            join
            // a missing or badly framed reply fails the run
            if (!ok) begin
                bad_count++;
                break;
            end
            exp_r = exp_reply(cmds[k].code, sensors_in);
            chk("reply bumper feel", exp_r[39:24], reply[39:24]);
            chk("reply third byte", {8'h0, exp_r[23:16]}, {8'h0, reply[23:16]});
            chk("reply heading", exp_r[15:0], reply[15:0]);
            chk("action seen", 16'(acts[k]), 16'(done_count - done_base));
            if (acts[k]) chk("action request", cmds[k], seen_act);
            if (k == 7) chk("arm refused", 16'h0000, {13'h0, arm_mode_out, arm_variant_out});
        end
        chk("mode flags", {11'h0, 1'b1, 1'b1, 1'b1, ARM_NAV},
            {11'h0, dc_motor_cfg_out, six_ranger_cfg_out, arm_mode_out, arm_variant_out});
        give_verdict();
    end
endmodule

bind rsc_port rsc_port_properties #(.BIT_CYCLES(BIT_CYCLES)) i_rsc_port_properties (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .host_tx_out(host_tx_out),
    .action_start_out(action_start_out),
    .action_out(action_out),
    .action_done_in(action_done_in),
    .arm_mode_out(arm_mode_out),
    .arm_variant_out(arm_variant_out)
);
`default_nettype wire
